//--- hw/light_alarm_defs.svh
`ifndef LIGHT_ALARM_DEFS_SVH
`define LIGHT_ALARM_DEFS_SVH

// Configuration word field positions
`define CFG_RANGE_HI 15
`define CFG_RANGE_LO 12
`define CFG_OVR_BIT 6
`define CFG_UNDR_BIT 5
`define CFG_LATCH_BIT 4
`define CFG_SENSE_BIT 3
`define CFG_EZERO_BIT 2
`define CFG_TALLY_HI 1
`define CFG_TALLY_LO 0

// Reset values of the writable fields
`define CFG_RANGE_RST 4'hC
`define CFG_LATCH_RST 1'h1
`define CFG_SENSE_RST 1'h0
`define CFG_EZERO_RST 1'h0
`define CFG_TALLY_RST 2'h0

// Range code that selects automatic full scale
`define RANGE_AUTO 4'hC

// Saturation point of the consecutive-fault counters
`define FAULT_CNT_MAX 4'h8

// Linear value width: 12-bit mantissa shifted by up to 15
`define LUX_W 27

`endif

//--- hw/light_alarm_pkg.sv
package light_alarm_pkg;
  typedef logic [3:0] fault_cnt_t;
  typedef logic [26:0] lux_t;
  typedef enum logic [1:0] {
    TALLY_ONE = 2'b00,
    TALLY_TWO = 2'b01,
    TALLY_FOUR = 2'b10,
    TALLY_EIGHT = 2'b11
  } fault_tally_e;
endpackage

//--- hw/light_limit_alarm_logic.sv
`timescale 1ns/100ps
`include "light_alarm_defs.svh"

// Overview of operation
// - The over flag sets after the result exceeds the high limit for the number of consecutive measurements chosen.
// - The under flag sets after the result falls below the low limit for the number of consecutive measurements chosen.
// - With the sticky select at 0, pin and flags follow the latest comparison with no clearing needed.
// - With the sticky select at 1, pin and flags stay asserted until the host clears them.
// - The sticky select is read/write and resets to 1.
// - With the pin sense at 0, an alarm actively drives the pin low.
// - With the pin sense at 1, an alarm releases the pin and no alarm drives it low.
// - With exponent zeroing set and a manual range code, the reported exponent reads as zero.
// - Exponent zeroing changes only the reported result, never the limit comparison.
// - The tally field codes 00, 01, 10, 11 ask for one, two, four or eight faults, and it resets to 00.
// - Result and both limits are turned into linear values before they are compared.

module light_limit_alarm_logic (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_cfg_wr,
  input wire logic [15:0] i_cfg_wdata,
  output logic [15:0] o_config,
  input wire logic [15:0] i_low_limit,
  input wire logic [15:0] i_high_limit,
  input wire logic i_result_valid,
  input wire logic [15:0] i_result,
  output logic [15:0] o_result_reg,
  input wire logic i_clear_evt,
  input wire logic i_alarm_pin,
  output logic o_alarm_out,
  output logic o_alarm_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields

  logic [3:0] range_q, range_d;
  logic latch_q, latch_d;
  logic sense_q, sense_d;
  logic ezero_q, ezero_d;
  light_alarm_pkg::fault_tally_e tally_q, tally_d;

  always_comb begin
    range_d = range_q;
    latch_d = latch_q;
    sense_d = sense_q;
    ezero_d = ezero_q;
    tally_d = tally_q;
    if (i_cfg_wr) begin
      range_d = i_cfg_wdata[`CFG_RANGE_HI:`CFG_RANGE_LO];
      latch_d = i_cfg_wdata[`CFG_LATCH_BIT];
      sense_d = i_cfg_wdata[`CFG_SENSE_BIT];
      ezero_d = i_cfg_wdata[`CFG_EZERO_BIT];
      tally_d = light_alarm_pkg::fault_tally_e'(i_cfg_wdata[`CFG_TALLY_HI:`CFG_TALLY_LO]);
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      range_q <= `CFG_RANGE_RST;
      latch_q <= `CFG_LATCH_RST;
      sense_q <= `CFG_SENSE_RST;
      ezero_q <= `CFG_EZERO_RST;
      tally_q <= light_alarm_pkg::fault_tally_e'(`CFG_TALLY_RST);
    end else begin
      range_q <= range_d;
      latch_q <= latch_d;
      sense_q <= sense_d;
      ezero_q <= ezero_d;
      tally_q <= tally_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Linear comparison

  light_alarm_pkg::lux_t res_lux;
  light_alarm_pkg::lux_t low_lux;
  light_alarm_pkg::lux_t high_lux;
  logic over_now;
  logic under_now;

  lux_linearize u_lin_res (
    .i_word(i_result),
    .o_lux(res_lux)
  );
  lux_linearize u_lin_low (
    .i_word(i_low_limit),
    .o_lux(low_lux)
  );
  lux_linearize u_lin_high (
    .i_word(i_high_limit),
    .o_lux(high_lux)
  );

  assign over_now = res_lux > high_lux;
  assign under_now = res_lux < low_lux;

  ////////////////////////////////////////////////////////////////////////////
  // Fault counters and flags

  light_alarm_pkg::fault_cnt_t need;
  light_alarm_pkg::fault_cnt_t hi_cnt_q, hi_cnt_d;
  light_alarm_pkg::fault_cnt_t lo_cnt_q, lo_cnt_d;
  logic hi_trip;
  logic lo_trip;
  logic ovr_q, ovr_d;
  logic undr_q, undr_d;
  logic alarm;

  always_comb begin
    case (tally_q)
      light_alarm_pkg::TALLY_ONE: need = 4'h1;
      light_alarm_pkg::TALLY_TWO: need = 4'h2;
      light_alarm_pkg::TALLY_FOUR: need = 4'h4;
      light_alarm_pkg::TALLY_EIGHT: need = 4'h8;
      default: need = 4'h1;
    endcase
    hi_cnt_d = hi_cnt_q;
    lo_cnt_d = lo_cnt_q;
    if (i_result_valid) begin
      hi_cnt_d = !over_now ? 4'h0 : (hi_cnt_q == `FAULT_CNT_MAX) ? hi_cnt_q : hi_cnt_q + 4'h1;
      lo_cnt_d = !under_now ? 4'h0 : (lo_cnt_q == `FAULT_CNT_MAX) ? lo_cnt_q : lo_cnt_q + 4'h1;
    end
    hi_trip = i_result_valid && over_now && (hi_cnt_d >= need);
    lo_trip = i_result_valid && under_now && (lo_cnt_d >= need);
    ovr_d = ovr_q;
    undr_d = undr_q;
    if (latch_q) begin
      if (i_clear_evt) begin
        ovr_d = 1'b0;
        undr_d = 1'b0;
      end
      if (hi_trip) begin
        ovr_d = 1'b1;
      end
      if (lo_trip) begin
        undr_d = 1'b1;
      end
    end else if (i_result_valid) begin
      ovr_d = hi_trip;
      undr_d = lo_trip;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_cnt_q <= 4'h0;
      lo_cnt_q <= 4'h0;
      ovr_q <= 1'b0;
      undr_q <= 1'b0;
    end else begin
      hi_cnt_q <= hi_cnt_d;
      lo_cnt_q <= lo_cnt_d;
      ovr_q <= ovr_d;
      undr_q <= undr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reported result

  logic [15:0] result_q, result_d;

  always_comb begin
    result_d = result_q;
    if (i_result_valid) begin
      result_d = i_result;
      if (ezero_q && (range_q < `RANGE_AUTO)) begin
        result_d[15:12] = 4'h0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_q <= 16'h0000;
    end else begin
      result_q <= result_d;
    end
  end

  assign o_result_reg = result_q;

  ////////////////////////////////////////////////////////////////////////////
  // Readback and alarm pin

  always_comb begin
    o_config = 16'h0000;
    o_config[`CFG_RANGE_HI:`CFG_RANGE_LO] = range_q;
    o_config[`CFG_OVR_BIT] = ovr_q;
    o_config[`CFG_UNDR_BIT] = undr_q;
    o_config[`CFG_LATCH_BIT] = latch_q;
    o_config[`CFG_SENSE_BIT] = sense_q;
    o_config[`CFG_EZERO_BIT] = ezero_q;
    o_config[`CFG_TALLY_HI:`CFG_TALLY_LO] = tally_q;
  end

  assign alarm = ovr_q | undr_q;
  // Open drain: only ever pulls low
  assign o_alarm_out = 1'b0;
  assign o_alarm_oe_n = sense_q ? alarm : !alarm;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  over_flag_set_a: assert property (hi_trip |=> ovr_q) else $error("over flag not set");
  under_flag_set_a: assert property (lo_trip |=> undr_q) else $error("under flag not set");
  transparent_follow_a: assert property (!latch_q && i_result_valid |=> ovr_q == $past(hi_trip) && undr_q == $past(lo_trip))
    else $error("transparent flags wrong");
  sticky_hold_a: assert property (latch_q && ovr_q && !i_clear_evt |=> ovr_q) else $error("sticky flag dropped");
  sticky_write_a: assert property (i_cfg_wr |=> o_config[`CFG_LATCH_BIT] == $past(i_cfg_wdata[`CFG_LATCH_BIT]))
    else $error("sticky select not written");
  pin_low_drive_a: assert property (!sense_q && alarm |-> !o_alarm_oe_n && !o_alarm_out)
    else $error("pin not pulled low");
  pin_inverted_a: assert property (sense_q |-> o_alarm_oe_n == alarm) else $error("inverted pin wrong");
  exp_masked_a: assert property (i_result_valid && ezero_q && range_q < `RANGE_AUTO |=> o_result_reg[15:12] == 4'h0)
    else $error("exponent not masked");
  mask_no_effect_a: assert property (i_result_valid && ezero_q && over_now && tally_q == light_alarm_pkg::TALLY_ONE
    |=> ovr_q) else $error("masking changed compare");
  tally_two_a: assert property (!latch_q && i_result_valid && tally_q == light_alarm_pkg::TALLY_TWO && hi_cnt_q == 4'h0
    |=> !ovr_q) else $error("single fault tripped tally two");
  linear_compare_a: assert property (i_result_valid && res_lux > high_lux && tally_q == light_alarm_pkg::TALLY_ONE
    |=> ovr_q) else $error("linear compare wrong");
  run_restart_a: assert property (i_result_valid && !over_now |=> hi_cnt_q == 4'h0) else $error("counter not cleared");

  over_latched_c: cover property (latch_q && hi_trip ##1 ovr_q [*3] ##1 !ovr_q);
  under_transparent_c: cover property (!latch_q && lo_trip ##1 undr_q);
  eight_run_c: cover property (tally_q == light_alarm_pkg::TALLY_EIGHT && hi_trip);
  inverted_alarm_c: cover property (sense_q && alarm && i_alarm_pin);

endmodule

//--- hw/lux_linearize.sv
`timescale 1ns/100ps
`include "light_alarm_defs.svh"

module lux_linearize (
  input wire logic [15:0] i_word,
  output light_alarm_pkg::lux_t o_lux
);
  // Mantissa shifted left by the exponent
  assign o_lux = light_alarm_pkg::lux_t'({15'h0000, i_word[11:0]} << i_word[15:12]);
endmodule

//--- sim/host_model.sv
`timescale 1ns/100ps

module host_model (
  input wire logic i_clock,
  input wire logic i_alarm_oe_n,
  input wire logic i_alarm_out,
  output logic o_cfg_wr,
  output logic [15:0] o_cfg_wdata,
  output logic o_clear_evt,
  output logic o_pin_level
);
  // External pull-up raises the released line; a driven line carries the output value
  assign o_pin_level = i_alarm_oe_n ? 1'b1 : i_alarm_out;

  initial begin
    o_cfg_wr = 1'b0;
    o_cfg_wdata = 16'h0000;
    o_clear_evt = 1'b0;
  end

  task automatic write_cfg(input logic [15:0] data);
    @(posedge i_clock);
    o_cfg_wr <= 1'b1;
    o_cfg_wdata <= data;
    @(posedge i_clock);
    o_cfg_wr <= 1'b0;
    // Released data bus shows no stale value
    o_cfg_wdata <= ~data;
    #1;
  endtask

  task automatic clear_flags();
    @(posedge i_clock);
    o_clear_evt <= 1'b1;
    @(posedge i_clock);
    o_clear_evt <= 1'b0;
    #1;
  endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/100ps

module tb;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic valid = 1'b0;
  logic [15:0] result = 16'h0000;
  logic [15:0] low_lim = 16'h1008;
  logic [15:0] high_lim = 16'h1080;
  logic cfg_wr, clear_evt, pin, oe_n, alarm_out;
  logic [15:0] cfg_wdata, cfg, res_reg;
  int err_total = 0;
  int checks = 0;
  // Linear levels: low 16, high 256
  localparam logic [15:0] OVER = 16'h2041;
  localparam logic [15:0] INSIDE = 16'h0100;
  localparam logic [15:0] UNDER = 16'h000F;

  always #4 i_clock = ~i_clock;

  host_model host (.i_clock(i_clock), .i_alarm_oe_n(oe_n), .i_alarm_out(alarm_out), .o_cfg_wr(cfg_wr),
    .o_cfg_wdata(cfg_wdata),
    .o_clear_evt(clear_evt), .o_pin_level(pin));

  light_limit_alarm_logic dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cfg_wr(cfg_wr),
    .i_cfg_wdata(cfg_wdata), .o_config(cfg), .i_low_limit(low_lim), .i_high_limit(high_lim),
    .i_result_valid(valid), .i_result(result), .o_result_reg(res_reg), .i_clear_evt(clear_evt),
    .i_alarm_pin(pin), .o_alarm_out(alarm_out), .o_alarm_oe_n(oe_n));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic meas(input logic [15:0] r);
    @(posedge i_clock);
    valid <= 1'b1;
    result <= r;
    @(posedge i_clock);
    valid <= 1'b0;
    result <= ~r;
    #1;
  endtask

  task automatic chk_alarm(input logic ovr, input logic undr, input logic oe);
    chk_bit(cfg[6], ovr);
    chk_bit(cfg[5], undr);
    chk_bit(oe_n, oe);
    chk_bit(pin, oe);
    chk_bit(alarm_out, 1'b0);
  endtask

  initial begin
    repeat (5000) @(posedge i_clock);
    err_total++;
    test_done();
  end

  initial begin
    int n;
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    #1;
    chk_word(cfg, 16'hC010);
    chk_word(res_reg, 16'h0000);
    chk_alarm(1'b0, 1'b0, 1'b1);
    host.write_cfg(16'hF07F);
    chk_word(cfg, 16'hF01F);
    for (int k = 0; k < 4; k++) begin
      n = 1 << k;
      host.write_cfg({4'hC, 10'h000, k[1:0]});
      repeat (n - 1) meas(OVER);
      chk_alarm(1'b0, 1'b0, 1'b1);
      meas(INSIDE);
      repeat (n - 1) meas(OVER);
      chk_alarm(1'b0, 1'b0, 1'b1);
      meas(OVER);
      chk_alarm(1'b1, 1'b0, 1'b0);
      meas(INSIDE);
      chk_alarm(1'b0, 1'b0, 1'b1);
    end
    host.write_cfg(16'hC001);
    meas(UNDER);
    chk_alarm(1'b0, 1'b0, 1'b1);
    meas(UNDER);
    chk_alarm(1'b0, 1'b1, 1'b0);
    meas(INSIDE);
    host.write_cfg(16'hC010);
    meas(OVER);
    meas(INSIDE);
    chk_alarm(1'b1, 1'b0, 1'b0);
    host.clear_flags();
    chk_alarm(1'b0, 1'b0, 1'b1);
    host.write_cfg(16'hC008);
    chk_alarm(1'b0, 1'b0, 1'b0);
    meas(OVER);
    chk_alarm(1'b1, 1'b0, 1'b1);
    host.write_cfg(16'h3004);
    meas(OVER);
    chk_word(res_reg, 16'h0041);
    chk_bit(cfg[6], 1'b1);
    host.write_cfg(16'hC004);
    meas(OVER);
    chk_word(res_reg, OVER);
    host.write_cfg(16'h3000);
    meas(OVER);
    chk_word(res_reg, OVER);
    // Same linear levels, other exponents: raw word order disagrees with lux order
    @(posedge i_clock);
    low_lim <= 16'h2004;
    high_lim <= 16'h2040;
    meas(16'h0101);
    chk_alarm(1'b1, 1'b0, 1'b0);
    meas(INSIDE);
    chk_alarm(1'b0, 1'b0, 1'b1);
    meas(UNDER);
    chk_alarm(1'b0, 1'b1, 1'b0);
    host.clear_flags();
    chk_alarm(1'b0, 1'b1, 1'b0);
    // Reset in mid-run with flags and fields away from their defaults
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    #1;
    chk_word(cfg, 16'hC010);
    chk_alarm(1'b0, 1'b0, 1'b1);
    @(posedge i_clock);
    i_rst_n <= 1'b1;
    #1;
    chk_word(res_reg, 16'h0000);
    chk_word(cfg, 16'hC010);
    // Trip and clear on one edge: the set wins
    fork
      host.clear_flags();
      meas(OVER);
    join
    chk_alarm(1'b1, 1'b0, 1'b0);
    meas(INSIDE);
    chk_alarm(1'b1, 1'b0, 1'b0);
    test_done();
  end
endmodule
